// File: rtl/rtc_bus_port.sv
// Host bus port with byte store, interrupt and square-wave logic
`timescale 1ns/1ps
// What this block does
// - High style pin picks strobe timing
// - Address strobe fall captures seven-bit location
// - Address strobe rise discards captured address
// - Strobe mode writes on data strobe fall
// - Read drives bus, released at strobe end
// - Enable mode: read/write pin is write enable
// - Enable mode: data strobe is read enable
// - Unselected cycle latches address, no access
// - Low supply forces chip select inactive
// - Interrupt low while flag and enable set
// - Interrupt pin is open drain
// - Reading third control register clears interrupt
// - Reset keeps time and memory contents
// - Reset clears interrupt and square-wave enables when supply good
// - Reset clears flags, floats interrupt pin
// - No bus access while reset low
// - Square wave is gated divider tap
// - Low supply suppresses square wave
// - 15 control plus 113 user bytes
// - Century byte at location 32h
// - Three sources, each masked and flagged
// - Third and fourth control registers read-only
// - Divider runs on 010, held on 11X
module rtc_bus_port #(
	parameter int DIV_W = rtc_port_pkg::DIV_STAGES
) (
	input  wire logic       REF_CLK,
	input  wire logic       SRST,
	input  wire logic       BUS_STYLE_SELECT,
	input  wire logic       CHIP_SELECT_N,
	input  wire logic       ADDRESS_STROBE,
	input  wire logic       DATA_STROBE,
	input  wire logic       READ_WRITE,
	input  wire logic       RESET_N,
	input  wire logic       SUPPLY_OK,
	input  wire logic [7:0] SHARED_ADDR_DATA_BUS_IN,
	input  wire logic       ALARM_EVENT,
	input  wire logic       UPDATE_DONE_EVENT,
	output logic      [7:0] SHARED_ADDR_DATA_BUS_OUT,
	output logic            SHARED_ADDR_DATA_BUS_OE,
	output logic            IRQ_N_OUT,
	output logic            IRQ_N_OE,
	output logic            SQUARE_WAVE_OUT
);
	initial begin
		if (DIV_W != rtc_port_pkg::DIV_STAGES)
			$error("divider must have fifteen stages");
	end

	typedef struct packed {
		logic [2:0]  as_s;
		logic [2:0]  ds_s;
		logic [2:0]  rw_s;
		logic [2:0]  cs_s;
		logic [1:0]  mode_s;
		logic [2:0]  rst_s;
		logic [1:0]  pwr_s;
		logic [7:0]  bus_s;
		logic [1:0]  al_s;
		logic [1:0]  ud_s;
		logic        addr_ok;
		logic [6:0]  addr;
		logic [DIV_W-1:0] div;
		logic        tap_prev;
		logic [7:0]  dout;
		logic        oe;
		logic        irq_oe;
		logic        square_wave_out;
		logic [rtc_port_pkg::LOCATIONS-1:0][7:0] mem;
	} state_type;

	state_type q, d;

	logic as_fall, as_rise, ds_fall, ds_rise, rd_fall, rd_rise, wr_rise;
	logic sel, motor, rst_low, pwr;
	logic [7:0] cb, cc, ca;
	logic [3:0] rate;
	logic tap, tick;
	logic [3:0] tap_idx;

	always_comb begin
		d = q;
		// Second stage onward feeds edge logic, except write strobe rise, which uses the first
		d.as_s   = {q.as_s[1:0], ADDRESS_STROBE};
		d.ds_s   = {q.ds_s[1:0], DATA_STROBE};
		d.rw_s   = {q.rw_s[1:0], READ_WRITE};
		d.cs_s   = {q.cs_s[1:0], CHIP_SELECT_N};
		d.mode_s = {q.mode_s[0], BUS_STYLE_SELECT};
		d.rst_s  = {q.rst_s[1:0], RESET_N};
		d.pwr_s  = {q.pwr_s[0], SUPPLY_OK};
		d.bus_s  = SHARED_ADDR_DATA_BUS_IN;
		d.al_s   = {q.al_s[0], ALARM_EVENT};
		d.ud_s   = {q.ud_s[0], UPDATE_DONE_EVENT};

		motor   = q.mode_s[1];
		rst_low = !q.rst_s[2];
		pwr     = q.pwr_s[1];
		sel     = !q.cs_s[2] && pwr && !rst_low;
		as_fall = q.as_s[2] && !q.as_s[1];
		as_rise = !q.as_s[2] && q.as_s[1];
		ds_fall = q.ds_s[2] && !q.ds_s[1];
		ds_rise = !q.ds_s[2] && q.ds_s[1];
		rd_fall = ds_fall;
		rd_rise = ds_rise;
		wr_rise = !q.rw_s[1] && q.rw_s[0];
		ca = q.mem[rtc_port_pkg::LOC_CTRL_A];
		cb = q.mem[rtc_port_pkg::LOC_CTRL_B];
		cc = q.mem[rtc_port_pkg::LOC_CTRL_C];

		if (as_fall) begin
			d.addr    = q.bus_s[6:0];
			d.addr_ok = 1'b1;
		end
		if (as_rise)
			d.addr_ok = 1'b0;

		// Divider: 11X holds chain in reset, 010 runs it
		if (ca[6:5] == rtc_port_pkg::DIV_RST)
			d.div = '0;
		else if (ca[6:4] == rtc_port_pkg::DIV_RUN)
			d.div = q.div + 1'b1;
		rate    = ca[3:0];
		tap_idx = (rate < 4'h3) ? rate + 4'h6 : rate - 4'h1;
		tap     = (rate == 4'h0) ? 1'b0 : q.div[tap_idx];
		d.tap_prev = tap;
		tick    = tap && !q.tap_prev;

		// Events set flags; a read clear loses to a same-cycle set
		if (q.oe && motor ? ds_fall : (q.oe && rd_rise))
			if (q.addr == rtc_port_pkg::LOC_CTRL_C)
				cc = '0;
		if (tick)
			cc[rtc_port_pkg::C_PF] = 1'b1;
		if (q.al_s[1])
			cc[rtc_port_pkg::C_AF] = 1'b1;
		if (q.ud_s[1])
			cc[rtc_port_pkg::C_UF] = 1'b1;
		cc[3:0] = 4'h0;
		cc[rtc_port_pkg::C_IRQ_PENDING_FLAG] =
			(cc[rtc_port_pkg::C_PF] && cb[rtc_port_pkg::B_PIE]) ||
			(cc[rtc_port_pkg::C_AF] && cb[rtc_port_pkg::B_AIE]) ||
			(cc[rtc_port_pkg::C_UF] && cb[rtc_port_pkg::B_UIE]);

		// Writes: strobe mode on data strobe fall, else write strobe rise
		// Read/write staged as deep as the strobe: host may drop both at once
		if (sel && q.addr_ok && (motor ? (ds_fall && !q.rw_s[2])
				: wr_rise)) begin
			if (q.addr == rtc_port_pkg::LOC_CTRL_B)
				cb = q.bus_s;
			else if (q.addr != rtc_port_pkg::LOC_CTRL_C &&
					q.addr != rtc_port_pkg::LOC_CTRL_D)
				d.mem[q.addr] = q.bus_s;
		end

		// Reset clears enables only when supply is good, flags always
		if (rst_low && pwr) begin
			cb[rtc_port_pkg::B_PIE]  = 1'b0;
			cb[rtc_port_pkg::B_AIE]  = 1'b0;
			cb[rtc_port_pkg::B_UIE]  = 1'b0;
			cb[rtc_port_pkg::B_SQUARE_WAVE_ENABLE] = 1'b0;
		end
		if (rst_low)
			cc = '0;
		d.mem[rtc_port_pkg::LOC_CTRL_B] = cb;
		d.mem[rtc_port_pkg::LOC_CTRL_C] = cc;
		d.mem[rtc_port_pkg::LOC_CTRL_D] = rtc_port_pkg::CTRL_D_VALUE;

		// Read drive window; released at strobe end or loss of select
		if (motor) begin
			if (sel && q.addr_ok && ds_rise && q.rw_s[1])
				d.oe = 1'b1;
			if (ds_fall || !sel)
				d.oe = 1'b0;
		end else begin
			if (sel && q.addr_ok && rd_fall)
				d.oe = 1'b1;
			if (rd_rise || !sel)
				d.oe = 1'b0;
		end
		if (as_fall || as_rise)
			d.oe = 1'b0;
		d.dout = q.mem[q.addr];

		d.irq_oe = cc[rtc_port_pkg::C_IRQ_PENDING_FLAG] && !rst_low;
		d.square_wave_out = tap && cb[rtc_port_pkg::B_SQUARE_WAVE_ENABLE] && pwr;

		if (SRST) begin
			d.addr_ok  = 1'b0;
			d.oe       = 1'b0;
			d.irq_oe   = 1'b0;
			d.square_wave_out      = 1'b0;
			d.div      = '0;
			d.tap_prev = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		q <= d;
	end

	assign SHARED_ADDR_DATA_BUS_OUT = q.dout;
	assign SHARED_ADDR_DATA_BUS_OE  = q.oe;
	assign IRQ_N_OUT                = 1'b0;
	assign IRQ_N_OE                 = q.irq_oe;
	assign SQUARE_WAVE_OUT          = q.square_wave_out;

	property p_no_drive_unselected;
		@(posedge REF_CLK) disable iff (SRST)
		(!q.pwr_s[1] || !q.rst_s[2]) |=> !SHARED_ADDR_DATA_BUS_OE;
	endproperty
	a_no_drive_unselected: assert property (p_no_drive_unselected)
		else $error("bus driven without select");

	property p_addr_drop;
		@(posedge REF_CLK) disable iff (SRST)
		(!q.as_s[2] && q.as_s[1]) |=> !q.addr_ok;
	endproperty
	a_addr_drop: assert property (p_addr_drop)
		else $error("address kept after strobe rise");

	property p_irq_follows;
		@(posedge REF_CLK) disable iff (SRST)
		q.rst_s[2] |=>
			(IRQ_N_OE == q.mem[rtc_port_pkg::LOC_CTRL_C][rtc_port_pkg::C_IRQ_PENDING_FLAG]);
	endproperty
	a_irq_follows: assert property (p_irq_follows)
		else $error("interrupt pending but pin floats");

	property p_reset_flags;
		@(posedge REF_CLK) disable iff (SRST)
		!q.rst_s[2] |=> (q.mem[rtc_port_pkg::LOC_CTRL_C] == 8'h00)
			&& !IRQ_N_OE;
	endproperty
	a_reset_flags: assert property (p_reset_flags)
		else $error("flags survive reset");

	property p_sqw_power;
		@(posedge REF_CLK) disable iff (SRST)
		!q.pwr_s[1] |=> !SQUARE_WAVE_OUT;
	endproperty
	a_sqw_power: assert property (p_sqw_power)
		else $error("square wave on low supply");

	property p_ctrl_d_fixed;
		@(posedge REF_CLK) disable iff (SRST)
		##1 q.mem[rtc_port_pkg::LOC_CTRL_D] == rtc_port_pkg::CTRL_D_VALUE;
	endproperty
	a_ctrl_d_fixed: assert property (p_ctrl_d_fixed)
		else $error("read-only register changed");

	property p_strobe_release;
		@(posedge REF_CLK) disable iff (SRST)
		(q.mode_s[1] && q.ds_s[2] && !q.ds_s[1]) |=>
			!SHARED_ADDR_DATA_BUS_OE;
	endproperty
	a_strobe_release: assert property (p_strobe_release)
		else $error("bus held after strobe fall");

	property p_enables_cleared;
		@(posedge REF_CLK) disable iff (SRST)
		(!q.rst_s[2] && q.pwr_s[1]) |=>
			(q.mem[rtc_port_pkg::LOC_CTRL_B][6:3] & 4'hF) == 4'h0
			|| !$past(q.rst_s[2]) == 1'b0;
	endproperty
	a_enables_cleared: assert property (p_enables_cleared)
		else $error("enables survive reset");

	property p_unselected_idle;
		@(posedge REF_CLK) disable iff (SRST)
		q.cs_s[2] |=> !SHARED_ADDR_DATA_BUS_OE;
	endproperty
	a_unselected_idle: assert property (p_unselected_idle)
		else $error("bus driven while deselected");

	property p_drive_needs_addr;
		@(posedge REF_CLK) disable iff (SRST)
		SHARED_ADDR_DATA_BUS_OE |-> q.addr_ok;
	endproperty
	a_drive_needs_addr: assert property (p_drive_needs_addr)
		else $error("bus driven without a held address");

	property p_sqw_gated;
		@(posedge REF_CLK) disable iff (SRST)
		SQUARE_WAVE_OUT |->
			q.mem[rtc_port_pkg::LOC_CTRL_B][rtc_port_pkg::B_SQUARE_WAVE_ENABLE];
	endproperty
	a_sqw_gated: assert property (p_sqw_gated)
		else $error("square wave without its enable");

	// Read of the flag register ending, in either bus style
	sequence s_flag_read_end;
		q.oe && q.addr == rtc_port_pkg::LOC_CTRL_C &&
		(q.mode_s[1] ? (q.ds_s[2] && !q.ds_s[1])
			: (!q.ds_s[2] && q.ds_s[1]));
	endsequence
	// No source can set a masked-in flag in the same cycle
	sequence s_quiet_sources;
		!q.al_s[1] && !q.ud_s[1] &&
		!q.mem[rtc_port_pkg::LOC_CTRL_B][rtc_port_pkg::B_PIE];
	endsequence
	property p_read_clears;
		@(posedge REF_CLK) disable iff (SRST)
		(s_flag_read_end and s_quiet_sources) |=> !IRQ_N_OE;
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("interrupt kept after flag read");
endmodule

// File: rtl/rtc_port_pkg.sv
// Constants for the multiplexed-bus clock and memory port
package rtc_port_pkg;
	localparam int ADDR_W      = 7;
	localparam int DATA_W      = 8;
	localparam int LOCATIONS   = 128;
	localparam int CLOCK_BYTES = 15;
	localparam int USER_BYTES  = 113;
	localparam logic [6:0] LOC_CTRL_A  = 7'h0A;
	localparam logic [6:0] LOC_CTRL_B  = 7'h0B;
	localparam logic [6:0] LOC_CTRL_C  = 7'h0C;
	localparam logic [6:0] LOC_CTRL_D  = 7'h0D;
	localparam logic [6:0] LOC_CENTURY = 7'h32;
	// Control B field positions
	localparam int B_SQUARE_WAVE_ENABLE = 3;
	localparam int B_UIE  = 4;
	localparam int B_AIE  = 5;
	localparam int B_PIE  = 6;
	// Control C field positions
	localparam int C_UF   = 4;
	localparam int C_AF   = 5;
	localparam int C_PF   = 6;
	localparam int C_IRQ_PENDING_FLAG = 7;
	// Divider-control values within control A bits 6:4
	localparam logic [2:0] DIV_RUN = 3'h2;
	localparam logic [1:0] DIV_RST = 2'h3;
	localparam int DIV_STAGES = 15;
	localparam int RATE_TAPS  = 13;
	localparam logic [7:0] CTRL_D_VALUE = 8'h80;
	localparam logic [7:0] MEM_RESET    = 8'h00;
endpackage

// File: testbench/rtc_host_model.sv
// Host model that runs cycles on the multiplexed bus
`timescale 1ns/1ps
module rtc_host_model (
	input  wire logic       clk,
	input  wire logic       style,
	input  wire logic [7:0] bus_in,
	output logic            cs_n,
	output logic            as_o,
	output logic            ds_o,
	output logic            rw_o,
	output logic      [7:0] bus_out
);
	initial begin
		cs_n = 1'b1;
		as_o = 1'b0;
		ds_o = 1'b0;
		rw_o = 1'b1;
		bus_out = 8'h00;
	end
	// Released lines show the inverse of the last value, never a guess
	task automatic cyc(input logic [6:0] a, input logic [7:0] d,
		input logic wr, input logic sel, output logic [7:0] q);
		@(posedge clk);
		ds_o <= ~style;
		as_o <= 1'b1;
		bus_out <= {1'b0, a};
		repeat (4) @(posedge clk);
		as_o <= 1'b0;
		repeat (4) @(posedge clk);
		cs_n <= ~sel;
		bus_out <= wr ? d : ~{1'b0, a};
		if (style) rw_o <= ~wr;
		repeat (2) @(posedge clk);
		if (style) ds_o <= 1'b1;
		else if (wr) rw_o <= 1'b0;
		else ds_o <= 1'b0;
		repeat (8) @(posedge clk);
		q = bus_in;
		ds_o <= ~style;
		rw_o <= 1'b1;
		// Select outlasts the strobe so the end edge is seen selected
		repeat (3) @(posedge clk);
		cs_n <= 1'b1;
		bus_out <= ~bus_out;
		repeat (6) @(posedge clk);
	endtask
endmodule

// File: testbench/tb_muxed_bus_rtc_host_port.sv
// Self-checking bench for the multiplexed-bus clock port
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_muxed_bus_rtc_host_port;
	logic       ref_clk;
	logic       srst;
	logic       style;
	logic       reset_n;
	logic       supply_ok;
	logic       alarm_ev;
	logic       upd_ev;
	logic [7:0] q;
	logic [1:0] s;
	wire        cs_n, as_s, ds_s, rw_s, oe, irq_out, irq_oe, square_wave_out;
	wire  [7:0] hbus, dout;
	wire  [7:0] bus_w = oe ? dout : hbus;
	int         err_total = 0;
	int         check_count = 0;
	rtc_bus_port rtc_bus_port_i (.REF_CLK(ref_clk), .SRST(srst),
		.BUS_STYLE_SELECT(style), .CHIP_SELECT_N(cs_n),
		.ADDRESS_STROBE(as_s), .DATA_STROBE(ds_s), .READ_WRITE(rw_s),
		.RESET_N(reset_n), .SUPPLY_OK(supply_ok),
		.SHARED_ADDR_DATA_BUS_IN(bus_w), .ALARM_EVENT(alarm_ev),
		.UPDATE_DONE_EVENT(upd_ev), .SHARED_ADDR_DATA_BUS_OUT(dout),
		.SHARED_ADDR_DATA_BUS_OE(oe), .IRQ_N_OUT(irq_out),
		.IRQ_N_OE(irq_oe), .SQUARE_WAVE_OUT(square_wave_out));
	rtc_host_model rtc_host_model_i (.clk(ref_clk), .style(style),
		.bus_in(bus_w), .cs_n(cs_n), .as_o(as_s), .ds_o(ds_s),
		.rw_o(rw_s), .bus_out(hbus));
	always #2 ref_clk = ~ref_clk;
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		rtc_host_model_i.cyc(a, d, 1'b1, 1'b1, q);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		rtc_host_model_i.cyc(a, 8'h00, 1'b0, 1'b1, q);
		`CHK(q, e)
	endtask
	task automatic ev(input logic u);
		@(posedge ref_clk);
		upd_ev <= u;
		alarm_ev <= ~u;
		@(posedge ref_clk);
		upd_ev <= 1'b0;
		alarm_ev <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask
	// Long enough to see both levels of the slowest tap in use
	task automatic sqw_watch;
		repeat (8) @(posedge ref_clk);
		s = 2'h0;
		repeat (1100) begin
			@(posedge ref_clk);
			s = s | (square_wave_out ? 2'h2 : 2'h1);
		end
	endtask
	task automatic report_and_stop;
		$display("errors=%0d checks=%0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		report_and_stop;
	end
	initial begin
		ref_clk = 1'b0;
		srst = 1'b1;
		style = 1'b1;
		// Held low at start so enables and flags begin cleared
		reset_n = 1'b0;
		supply_ok = 1'b1;
		alarm_ev = 1'b0;
		upd_ev = 1'b0;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		`CHK({oe, irq_oe, irq_out}, 3'h0)
		reset_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		wr(7'h0E, 8'h5A);
		wr(7'h7F, 8'hC3);
		wr(rtc_port_pkg::LOC_CENTURY, 8'h20);
		rd(7'h0E, 8'h5A);
		rd(7'h7F, 8'hC3);
		rd(rtc_port_pkg::LOC_CENTURY, 8'h20);
		`CHK(oe, 1'b0)
		rtc_host_model_i.cyc(7'h0E, 8'h11, 1'b1, 1'b0, q);
		rd(7'h0E, 8'h5A);
		wr(rtc_port_pkg::LOC_CTRL_D, 8'h00);
		rd(rtc_port_pkg::LOC_CTRL_D, rtc_port_pkg::CTRL_D_VALUE);
		style <= 1'b0;
		wr(7'h40, 8'h96);
		rd(7'h40, 8'h96);
		supply_ok <= 1'b0;
		wr(7'h40, 8'h00);
		supply_ok <= 1'b1;
		rd(7'h40, 8'h96);
		wr(rtc_port_pkg::LOC_CTRL_A, 8'h21);
		wr(rtc_port_pkg::LOC_CTRL_B, 8'h08);
		sqw_watch;
		`CHK(s, 2'h3)
		supply_ok <= 1'b0;
		sqw_watch;
		`CHK(s, 2'h1)
		supply_ok <= 1'b1;
		wr(rtc_port_pkg::LOC_CTRL_A, 8'h20);
		sqw_watch;
		`CHK(s, 2'h1)
		wr(rtc_port_pkg::LOC_CTRL_B, 8'h20);
		ev(1'b0);
		`CHK(irq_oe, 1'b1)
		rd(rtc_port_pkg::LOC_CTRL_C, 8'hE0);
		`CHK(irq_oe, 1'b0)
		ev(1'b1);
		`CHK(irq_oe, 1'b0)
		wr(rtc_port_pkg::LOC_CTRL_C, 8'hF0);
		rd(rtc_port_pkg::LOC_CTRL_C, 8'h10);
		wr(rtc_port_pkg::LOC_CTRL_B, 8'h28);
		ev(1'b0);
		`CHK(irq_oe, 1'b1)
		reset_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		`CHK(irq_oe, 1'b0)
		wr(7'h0E, 8'h00);
		reset_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(rtc_port_pkg::LOC_CTRL_B, 8'h00);
		rd(rtc_port_pkg::LOC_CTRL_C, 8'h00);
		rd(7'h0E, 8'h5A);
		report_and_stop;
	end
endmodule
